// ---- design/scrc_pkg.sv ----
package scrc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] SCRC_OFF_GATE    = 8'h00;
  localparam logic [7:0] SCRC_OFF_PDIV0   = 8'h04;
  localparam logic [7:0] SCRC_OFF_PDIV1   = 8'h08;
  localparam logic [7:0] SCRC_OFF_PRST    = 8'h0C;
  localparam logic [7:0] SCRC_OFF_BUSDIV  = 8'h10;
  localparam logic [7:0] SCRC_OFF_RSTFLG  = 8'h14;
  localparam logic [7:0] SCRC_OFF_LVD     = 8'h18;
  localparam logic [7:0] SCRC_OFF_PINREL  = 8'h1C;
  localparam logic [7:0] SCRC_OFF_DBGREL  = 8'h20;
  localparam logic [7:0] SCRC_OFF_CLKCFG  = 8'h24;

  // Values after reset
  localparam logic [31:0] SCRC_RST_GATE   = 32'h0100_0008;
  localparam logic [4:0]  SCRC_RST_FLAGS  = 5'h11;
  localparam logic [2:0]  SCRC_RST_SRC    = 3'h0;

  // Writable bits of each register
  localparam logic [31:0] SCRC_MASK_GATE  = 32'h71F3_3BC8;
  localparam logic [31:0] SCRC_MASK_PDIV0 = 32'h7777_7777;
  localparam logic [31:0] SCRC_MASK_PDIV1 = 32'hF770_7777;
  localparam logic [31:0] SCRC_MASK_PRST  = 32'h07F3_3BCF;
  localparam logic [31:0] SCRC_MASK_LVD   = 32'h0000_C033;

  // Field positions
  localparam int SCRC_POS_CKSRC   = 28;
  localparam int SCRC_POS_CKDIV   = 28;
  localparam int SCRC_POS_LVD_ON  = 15;
  localparam int SCRC_POS_LVD_RST = 14;
  localparam int SCRC_POS_LVD_IRQ = 4;
  localparam int SCRC_POS_LVD_RTH = 0;
  localparam int SCRC_POS_SRCST   = 4;

  // Divider limits and structure
  localparam int SCRC_NUM_PDIV       = 14;
  localparam int SCRC_AUDIO_PDIV     = 7;
  localparam int SCRC_WDOG_PDIV      = 12;
  localparam logic [3:0] SCRC_BUSDIV_MAX = 4'h9;
  localparam logic [2:0] SCRC_PDIV_MAX   = 3'h4;
  localparam logic [2:0] SCRC_WDOG_MAX   = 3'h5;
  localparam logic [2:0] SCRC_SRC_MAX    = 3'h4;

  // Source bit indices; main clock codes equal the index
  localparam int SCRC_SRC_FAST_RC   = 0;
  localparam int SCRC_SRC_SLOW_RC   = 1;
  localparam int SCRC_SRC_FAST_XTAL = 2;
  localparam int SCRC_SRC_SLOW_XTAL = 3;
  localparam int SCRC_SRC_PLL       = 4;
  localparam int SCRC_SRC_AUDIO     = 5;

  typedef struct packed {
    logic audio_crystal;
    logic pll;
    logic external_slow_crystal;
    logic external_fast_crystal;
    logic internal_slow_rc;
    logic internal_fast_rc;
  } scrc_src_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scrc_bus_type;

  typedef struct packed {
    logic power_on;
    logic pin;
    logic brownout;
    logic watchdog;
    logic software;
  } scrc_rst_event_type;

endpackage

// ---- design/scrc_top.sv ----
// Functional notes
// - Source select codes 0..4 pick main clock
// - Bus clock is main clock over 2^code
// - Deep power-down wake is not recorded here
// - Power-on flag bit4, resets 1, write-0 clears
// - Pin reset flag bit3, write-0 clears
// - Brownout reset flag bit2, write-0 clears
// - Watchdog reset flag bit1, write-0 clears
// - Software flag bit0, resets 1, write-0 clears
// - Detector on bit15; reset needs bit14 too
// - Interrupt threshold code chooses four levels
// - Reset threshold code, 11 reserved
// - Reset pin release frees pin for GPIO
// - Debug pin release frees both debug pins
// - Gated peripheral reads return zero
// - Nonzero clock-out source overrides shared GPIO
// - Clock-out source encoding selects output clock
// - Gate bits gate bus clock; two reset 1
// - Peripheral dividers 1..16, audio from crystal
// - Clock-out divider 2^code, codes 0..9
// - Watchdog divider 1..32, codes 0..5
// - Peripheral reset bits pulse and self-clear
// - Source switch waits for target ready
// - Internal fast RC after reset
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module scrc_top
  import scrc_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire scrc_bus_type       bus_in,
  input  wire scrc_src_type       src_level_in,
  input  wire scrc_src_type       src_ready_in,
  input  wire scrc_rst_event_type rst_event_in,
  input  wire logic               brownout_irq_below_in,
  input  wire logic               brownout_rst_below_in,
  input  wire logic [4:0]         periph_index_in,
  input  wire logic [31:0]        periph_rdata_in,
  output logic [31:0]             read_data_out,
  output logic [2:0]              main_clock_source_state_out,
  output logic                    main_clock_tick_out,
  output logic                    bus_clock_tick_out,
  output logic [31:0]             periph_bus_tick_out,
  output logic [13:0]             periph_div_tick_out,
  output logic [31:0]             periph_reset_out,
  output logic [31:0]             periph_rdata_out,
  output logic                    clock_output_out,
  output logic                    clock_output_override_out,
  output logic                    reset_pin_gpio_out,
  output logic                    debug_pins_gpio_out,
  output logic                    brownout_detector_on_out,
  output logic [1:0]              brownout_irq_threshold_out,
  output logic [1:0]              brownout_reset_threshold_out,
  output logic                    brownout_irq_out,
  output logic                    brownout_reset_req_out
);

  typedef struct packed {
    logic [31:0]                    gate;
    logic [31:0]                    pdiv0;
    logic [31:0]                    pdiv1;
    logic [31:0]                    prst;
    logic [3:0]                     bus_code;
    logic [4:0]                     flags;
    logic [31:0]                    lvd;
    logic                           pin_rel;
    logic                           dbg_rel;
    logic [2:0]                     sel;
    logic [2:0]                     state;
    logic [5:0]                     src_prev;
    logic                           main_tick;
    logic [8:0]                     bus_cnt;
    logic [3:0]                     bus_app;
    logic                           bus_tick;
    logic [SCRC_NUM_PDIV-1:0][4:0]  pcnt;
    logic [SCRC_NUM_PDIV-1:0][2:0]  papp;
    logic [SCRC_NUM_PDIV-1:0]       ptick;
    logic [31:0]                    pbus_tick;
    logic [8:0]                     ck_cnt;
    logic [3:0]                     ck_app;
    logic                           ck_out;
    logic                           ck_ovr;
    logic [31:0]                    rdata;
    logic [31:0]                    prd;
    logic                           lvd_irq;
    logic                           lvd_rst;
  } scrc_state_type;

  scrc_state_type st_r;
  scrc_state_type st_nxt;

  // Bit position of a peripheral divider field in its register
  function automatic int pdiv_pos(input int idx);
    if (idx < 8) begin
      return idx * 4;
    end else if (idx < 12) begin
      return (idx - 8) * 4;
    end else begin
      return (idx - 8) * 4 + 4;
    end
  endfunction

  // Source index for a clock-output code; code 1 is the bus clock
  function automatic int ckout_idx(input logic [2:0] code);
    unique case (code)
      3'h2:    return SCRC_SRC_PLL;
      3'h3:    return SCRC_SRC_SLOW_RC;
      3'h4:    return SCRC_SRC_FAST_RC;
      3'h5:    return SCRC_SRC_SLOW_XTAL;
      3'h6:    return SCRC_SRC_FAST_XTAL;
      3'h7:    return SCRC_SRC_AUDIO;
      default: return SCRC_SRC_FAST_RC;
    endcase
  endfunction

  // All register and clock logic in one next-state process
  always_comb begin
    logic [5:0]  lvl;
    logic [5:0]  rise;
    logic        mtick;
    logic        btick;
    logic        stick;
    logic [2:0]  code;
    logic [2:0]  lim;
    logic [2:0]  cksrc;
    logic        ck_edge;
    logic        ck_lvl;
    logic [4:0]  clr;
    logic        wr_hit;
    lvl     = 6'(src_level_in);
    rise    = lvl & ~st_r.src_prev;
    mtick   = 1'b0;
    btick   = 1'b0;
    stick   = 1'b0;
    code    = 3'h0;
    lim     = 3'h0;
    cksrc   = st_r.gate[SCRC_POS_CKSRC +: 3];
    ck_edge = 1'b0;
    ck_lvl  = 1'b0;
    clr     = 5'h00;
    wr_hit  = bus_in.wr;
    st_nxt  = st_r;
    st_nxt.src_prev = lvl;

    // Register writes; reserved bits are masked off
    st_nxt.prst = 32'h0000_0000;
    if (wr_hit) begin
      unique case (bus_in.addr)
        SCRC_OFF_GATE:   st_nxt.gate = bus_in.wdata & SCRC_MASK_GATE;
        SCRC_OFF_PDIV0:  st_nxt.pdiv0 = bus_in.wdata & SCRC_MASK_PDIV0;
        SCRC_OFF_PDIV1:  st_nxt.pdiv1 = bus_in.wdata & SCRC_MASK_PDIV1;
        SCRC_OFF_PRST:   st_nxt.prst = bus_in.wdata & SCRC_MASK_PRST;
        SCRC_OFF_BUSDIV: st_nxt.bus_code = bus_in.wdata[3:0];
        SCRC_OFF_RSTFLG: clr = ~bus_in.wdata[4:0];
        SCRC_OFF_LVD:    st_nxt.lvd = bus_in.wdata & SCRC_MASK_LVD;
        SCRC_OFF_PINREL: st_nxt.pin_rel = bus_in.wdata[0];
        SCRC_OFF_DBGREL: st_nxt.dbg_rel = bus_in.wdata[0];
        SCRC_OFF_CLKCFG: st_nxt.sel = bus_in.wdata[2:0];
        default: ;
      endcase
    end

    // Reset cause flags: a new event wins over a write-0 clear
    st_nxt.flags[4] = (st_r.flags[4] & ~clr[4]) | rst_event_in.power_on;
    st_nxt.flags[3] = (st_r.flags[3] & ~clr[3])
                      | (rst_event_in.pin & ~st_r.pin_rel);
    st_nxt.flags[2] = (st_r.flags[2] & ~clr[2]) | rst_event_in.brownout;
    st_nxt.flags[1] = (st_r.flags[1] & ~clr[1]) | rst_event_in.watchdog;
    st_nxt.flags[0] = (st_r.flags[0] & ~clr[0]) | rst_event_in.software;

    // Switch only to a legal, ready source; reserved codes are ignored
    if (st_r.sel <= SCRC_SRC_MAX && st_r.sel != st_r.state
        && src_ready_in[st_r.sel]) begin
      st_nxt.state = st_r.sel;
    end
    mtick = rise[st_r.state];
    st_nxt.main_tick = mtick;

    // Bus divider; a new code is taken only when a period completes
    if (mtick) begin
      if (st_r.bus_cnt == 9'((10'h001 << st_r.bus_app) - 10'h001)) begin
        st_nxt.bus_cnt = 9'h000;
        btick = 1'b1;
        if (st_r.bus_code <= SCRC_BUSDIV_MAX) begin
          st_nxt.bus_app = st_r.bus_code;
        end
      end else begin
        st_nxt.bus_cnt = st_r.bus_cnt + 9'h001;
      end
    end
    st_nxt.bus_tick  = btick;
    // Clock-out source bits share the gate register but gate no peripheral bus clock
    st_nxt.pbus_tick = {32{btick}} & st_r.gate & ~(32'h0000_0007 << SCRC_POS_CKSRC);

    // Peripheral dividers; audio divides its crystal, others the bus clock
    for (int i = 0; i < SCRC_NUM_PDIV; i++) begin
      code  = (i < 8) ? st_r.pdiv0[pdiv_pos(i) +: 3] : st_r.pdiv1[pdiv_pos(i) +: 3];
      lim   = (i == SCRC_WDOG_PDIV) ? SCRC_WDOG_MAX : SCRC_PDIV_MAX;
      stick = (i == SCRC_AUDIO_PDIV) ? rise[SCRC_SRC_AUDIO] : btick;
      st_nxt.ptick[i] = 1'b0;
      if (stick) begin
        if (st_r.pcnt[i] == 5'((6'h01 << st_r.papp[i]) - 6'h01)) begin
          st_nxt.pcnt[i]  = 5'h00;
          st_nxt.ptick[i] = 1'b1;
          if (code <= lim) begin
            st_nxt.papp[i] = code;
          end
        end else begin
          st_nxt.pcnt[i] = st_r.pcnt[i] + 5'h01;
        end
      end
    end

    // Clock output: /1 follows the source, else toggles every 2^(n-1) edges
    ck_edge = (cksrc == 3'h1) ? btick : rise[ckout_idx(cksrc)];
    ck_lvl  = (cksrc == 3'h1) ? btick : lvl[ckout_idx(cksrc)];
    st_nxt.ck_ovr = (cksrc != 3'h0);
    if (cksrc == 3'h0) begin
      st_nxt.ck_out = 1'b0;
      st_nxt.ck_cnt = 9'h000;
    end else if (st_r.ck_app == 4'h0) begin
      st_nxt.ck_out = ck_lvl;
      if (ck_edge && st_r.pdiv1[SCRC_POS_CKDIV +: 4] <= SCRC_BUSDIV_MAX) begin
        st_nxt.ck_app = st_r.pdiv1[SCRC_POS_CKDIV +: 4];
      end
    end else if (ck_edge) begin
      if (st_r.ck_cnt == 9'((10'h001 << (st_r.ck_app - 4'h1)) - 10'h001)) begin
        st_nxt.ck_cnt = 9'h000;
        st_nxt.ck_out = ~st_r.ck_out;
        if (st_r.ck_out && st_r.pdiv1[SCRC_POS_CKDIV +: 4] <= SCRC_BUSDIV_MAX) begin
          st_nxt.ck_app = st_r.pdiv1[SCRC_POS_CKDIV +: 4];
        end
      end else begin
        st_nxt.ck_cnt = st_r.ck_cnt + 9'h001;
      end
    end

    // Brownout detector gating
    st_nxt.lvd_irq = st_r.lvd[SCRC_POS_LVD_ON] & brownout_irq_below_in;
    st_nxt.lvd_rst = st_r.lvd[SCRC_POS_LVD_ON] & st_r.lvd[SCRC_POS_LVD_RST]
                     & brownout_rst_below_in;

    // Peripheral read return, forced to zero while its clock is gated
    st_nxt.prd = st_r.gate[periph_index_in] ? periph_rdata_in : 32'h0000_0000;

    // Read data stand for one cycle only
    st_nxt.rdata = 32'h0000_0000;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        SCRC_OFF_GATE:   st_nxt.rdata = st_r.gate;
        SCRC_OFF_PDIV0:  st_nxt.rdata = st_r.pdiv0;
        SCRC_OFF_PDIV1:  st_nxt.rdata = st_r.pdiv1;
        SCRC_OFF_PRST:   st_nxt.rdata = st_r.prst;
        SCRC_OFF_BUSDIV: st_nxt.rdata = {28'h000_0000, st_r.bus_code};
        SCRC_OFF_RSTFLG: st_nxt.rdata = {27'h000_0000, st_r.flags};
        SCRC_OFF_LVD:    st_nxt.rdata = st_r.lvd;
        SCRC_OFF_PINREL: st_nxt.rdata = {31'h0000_0000, st_r.pin_rel};
        SCRC_OFF_DBGREL: st_nxt.rdata = {31'h0000_0000, st_r.dbg_rel};
        SCRC_OFF_CLKCFG: st_nxt.rdata = {25'h000_0000, st_r.state, 1'b0, st_r.sel};
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; synchronous reset to documented defaults
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_r       <= '0;
      st_r.gate  <= SCRC_RST_GATE;
      st_r.flags <= SCRC_RST_FLAGS;
      st_r.sel   <= SCRC_RST_SRC;
      st_r.state <= SCRC_RST_SRC;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs taken straight from the state register
  assign read_data_out                = st_r.rdata;
  assign main_clock_source_state_out  = st_r.state;
  assign main_clock_tick_out          = st_r.main_tick;
  assign bus_clock_tick_out           = st_r.bus_tick;
  assign periph_bus_tick_out          = st_r.pbus_tick;
  assign periph_div_tick_out          = st_r.ptick;
  assign periph_reset_out             = st_r.prst;
  assign periph_rdata_out             = st_r.prd;
  assign clock_output_out             = st_r.ck_out;
  assign clock_output_override_out    = st_r.ck_ovr;
  assign reset_pin_gpio_out           = st_r.pin_rel;
  assign debug_pins_gpio_out          = st_r.dbg_rel;
  assign brownout_detector_on_out     = st_r.lvd[SCRC_POS_LVD_ON];
  assign brownout_irq_threshold_out   = st_r.lvd[SCRC_POS_LVD_IRQ +: 2];
  assign brownout_reset_threshold_out = st_r.lvd[SCRC_POS_LVD_RTH +: 2];
  assign brownout_irq_out             = st_r.lvd_irq;
  assign brownout_reset_req_out       = st_r.lvd_rst;

endmodule // scrc_top

// ---- dv/scrc_top_assertions.sv ----
`timescale 1ns/10ps
module scrc_checker
  import scrc_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire scrc_bus_type bus_in,
  input  wire scrc_src_type src_ready_in,
  input  wire logic         brownout_irq_below_in,
  input  wire logic         brownout_rst_below_in,
  input  wire logic [31:0]  periph_rdata_in,
  input  wire logic [31:0]  periph_rdata_out,
  input  wire logic [2:0]   main_clock_source_state_out,
  input  wire logic [31:0]  periph_reset_out,
  input  wire logic         clock_output_out,
  input  wire logic         clock_output_override_out,
  input  wire logic         brownout_detector_on_out,
  input  wire logic         brownout_irq_out,
  input  wire logic         brownout_reset_req_out
);
  logic [5:0] ready_r;

  // Ready levels one edge back, so a switch can be tied to the readiness it saw
  always_ff @(posedge clk_in) begin
    ready_r <= src_ready_in;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // A write that lands in the peripheral reset register
  sequence prst_wr_s;
    bus_in.wr && (bus_in.addr == SCRC_OFF_PRST);
  endsequence

  prst_pulse_a: assert property (prst_wr_s |=>
    periph_reset_out == ($past(bus_in.wdata) & SCRC_MASK_PRST)) else $error("reset pulse wrong");
  prst_clear_a: assert property (!(bus_in.wr && bus_in.addr == SCRC_OFF_PRST) |=>
    periph_reset_out == 32'h0) else $error("reset pulse not cleared");
  gated_read_a: assert property (periph_rdata_out == 32'h0 ||
    periph_rdata_out == $past(periph_rdata_in)) else $error("gated read data wrong");
  irq_path_a: assert property (brownout_irq_out ==
    $past(brownout_detector_on_out && brownout_irq_below_in)) else $error("brownout irq wrong");
  rst_path_a: assert property (brownout_reset_req_out |->
    $past(brownout_detector_on_out) && $past(brownout_rst_below_in)) else $error("brownout req");
  clkout_idle_a: assert property (!clock_output_override_out |->
    !clock_output_out) else $error("clock out runs while disabled");
  src_ready_a: assert property ($changed(main_clock_source_state_out) |->
    ready_r[main_clock_source_state_out]) else $error("switch to unready source");
  src_legal_a: assert property (main_clock_source_state_out <= 3'h4)
    else $error("source state out of range");
  reset_src_a: assert property ($rose(reset_n_in) |->
    main_clock_source_state_out == 3'h0) else $error("source not fast rc after reset");
endmodule // scrc_checker

bind scrc_top scrc_checker scrc_checker_i (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus_in), .src_ready_in(src_ready_in),
  .brownout_irq_below_in(brownout_irq_below_in), .brownout_rst_below_in(brownout_rst_below_in),
  .periph_rdata_in(periph_rdata_in), .periph_rdata_out(periph_rdata_out),
  .main_clock_source_state_out(main_clock_source_state_out),
  .periph_reset_out(periph_reset_out), .clock_output_out(clock_output_out),
  .clock_output_override_out(clock_output_override_out),
  .brownout_detector_on_out(brownout_detector_on_out), .brownout_irq_out(brownout_irq_out),
  .brownout_reset_req_out(brownout_reset_req_out));

// ---- dv/tb_scrc_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_scrc_top
  import scrc_pkg::*;
;
  logic               clk_in = 1'b0;
  logic               reset_n_in = 1'b0;
  scrc_bus_type       bus_r = '0;
  scrc_src_type       lvl_r = '0;
  scrc_src_type       rdy_r = 6'h01;
  scrc_rst_event_type evt_r = '0;
  logic               irq_below_r = 1'b0;
  logic               rst_below_r = 1'b0;
  logic [31:0]        prd_r = 32'h0;
  logic [31:0]        rdata, preset, prdout, pbtick, d;
  logic [13:0]        pdtick;
  logic [2:0]         state;
  logic [1:0]         thr_i, thr_r;
  logic               btick, ckout, ovr, gpio_rst, gpio_dbg, lvd_irq, lvd_req;
  logic               mtick, lvd_on;
  logic [4:0]         pidx_r = 5'h03;
  logic [7:0]         amap [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18};
  int                 bad_count = 0;
  int                 check_count = 0;
  integer             seed = 41;

  scrc_top scrc_top_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus_r), .src_level_in(lvl_r),
    .src_ready_in(rdy_r), .rst_event_in(evt_r), .brownout_irq_below_in(irq_below_r),
    .brownout_rst_below_in(rst_below_r), .periph_index_in(pidx_r), .periph_rdata_in(prd_r),
    .read_data_out(rdata), .main_clock_source_state_out(state), .main_clock_tick_out(mtick),
    .bus_clock_tick_out(btick), .periph_bus_tick_out(pbtick), .periph_div_tick_out(pdtick),
    .periph_reset_out(preset), .periph_rdata_out(prdout), .clock_output_out(ckout),
    .clock_output_override_out(ovr), .reset_pin_gpio_out(gpio_rst),
    .debug_pins_gpio_out(gpio_dbg), .brownout_detector_on_out(lvd_on),
    .brownout_irq_threshold_out(thr_i), .brownout_reset_threshold_out(thr_r),
    .brownout_irq_out(lvd_irq), .brownout_reset_req_out(lvd_req));

  // Clock, and all oscillators toggling every cycle so one source edge is two cycles
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) lvl_r <= ~lvl_r;

  // Writable bits; reserved divider codes are stored, so the bus divider keeps 4 bits
  function automatic logic [31:0] mask(input logic [7:0] a);
    case (a)
      SCRC_OFF_GATE: return SCRC_MASK_GATE;
      SCRC_OFF_PDIV0: return SCRC_MASK_PDIV0;
      SCRC_OFF_PDIV1: return SCRC_MASK_PDIV1;
      SCRC_OFF_LVD: return SCRC_MASK_LVD;
      default: return 32'h0000_000F;
    endcase
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: return btick;
      1: return pdtick[0];
      2: return pdtick[12];
      4: return pbtick[3];
      5: return mtick;
      6: return pdtick[7];
      default: return ckout;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    bus_r <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_r.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk_in);
    bus_r <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_r.rd <= 1'b0;
    #1;
    `CHK("read_data", ex, rdata)
  endtask

  // Rise-to-rise gap, skipping the first period that may still run on the old code
  task automatic gap(input int s, input int ex);
    int n, e, g;
    logic p;
    n = 0;
    e = 0;
    g = 0;
    p = 1'b1;
    while (e < 3 && n < 5000) begin
      @(posedge clk_in);
      #1;
      n++;
      g++;
      if (pick(s) === 1'b1 && p !== 1'b1) begin
        e++;
        if (e < 3) g = 0;
      end
      p = pick(s);
    end
    `CHK("tick_gap", ex, g)
  endtask

  task automatic pulse_evt(input logic [4:0] v);
    @(posedge clk_in);
    evt_r <= v;
    @(posedge clk_in);
    evt_r <= '0;
  endtask

  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run of a few thousand cycles
  initial begin
    repeat (40000) @(posedge clk_in);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(SCRC_OFF_RSTFLG, 32'h11);
    rd(SCRC_OFF_GATE, SCRC_RST_GATE);
    rd(SCRC_OFF_CLKCFG, 32'h0);
    gap(5, 2);
    rd(8'h28, 32'h0);
    wr(SCRC_OFF_RSTFLG, 32'h0);
    rd(SCRC_OFF_RSTFLG, 32'h0);
    for (int i = 0; i < 5; i++) begin
      pulse_evt(5'(1 << i));
      wr(SCRC_OFF_RSTFLG, 32'h1F);
      rd(SCRC_OFF_RSTFLG, 32'h1 << i);
      wr(SCRC_OFF_RSTFLG, 32'h0);
    end
    wr(SCRC_OFF_PINREL, 32'h1);
    wr(SCRC_OFF_DBGREL, 32'hFFFF_FFFF);
    pulse_evt(5'h08);
    rd(SCRC_OFF_RSTFLG, 32'h0);
    `CHK("pin_gpio", 1'b1, gpio_rst)
    `CHK("dbg_gpio", 1'b1, gpio_dbg)
    rd(SCRC_OFF_DBGREL, 32'h1);
    wr(SCRC_OFF_PINREL, 32'h0);
    // Random traffic over the plain read-write registers
    for (int i = 0; i < 25; i++) begin
      d = $random(seed);
      wr(amap[i % 5], d);
      rd(amap[i % 5], d & mask(amap[i % 5]));
      if (i % 5 == 0) `CHK("override", d[30:28] != 3'h0, ovr)
    end
    for (int i = 0; i < 8; i++) begin
      d = (i < 2) ? (32'h1 << (26 - 2 * i)) : $random(seed);
      wr(SCRC_OFF_PRST, d);
      `CHK("prst_pulse", d & SCRC_MASK_PRST, preset)
      @(posedge clk_in);
      #1;
      `CHK("prst_clear", 32'h0, preset)
    end
    wr(SCRC_OFF_LVD, 32'h0000_C032);
    @(posedge clk_in);
    irq_below_r <= 1'b1;
    rst_below_r <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("lvd_irq", 1'b1, lvd_irq)
    `CHK("lvd_req", 1'b1, lvd_req)
    `CHK("lvd_on", 1'b1, lvd_on)
    `CHK("lvd_thr", 4'hE, {thr_i, thr_r})
    wr(SCRC_OFF_LVD, 32'h0000_8000);
    @(posedge clk_in);
    #1;
    `CHK("lvd_req_off", 1'b0, lvd_req)
    wr(SCRC_OFF_LVD, 32'h0);
    // Source switch held off until the target reports ready
    wr(SCRC_OFF_CLKCFG, 32'h2);
    repeat (3) @(posedge clk_in);
    rd(SCRC_OFF_CLKCFG, 32'h02);
    @(posedge clk_in);
    rdy_r <= 6'h3F;
    rd(SCRC_OFF_CLKCFG, 32'h22);
    wr(SCRC_OFF_CLKCFG, 32'h5);
    `CHK("src_state", 3'h2, state)
    gap(5, 2);
    wr(SCRC_OFF_CLKCFG, 32'h0);
    wr(SCRC_OFF_PDIV0, 32'h0);
    wr(SCRC_OFF_PDIV1, 32'h0);
    for (int n = 0; n < 4; n++) begin
      wr(SCRC_OFF_BUSDIV, 32'(n));
      gap(0, 2 << n);
    end
    wr(SCRC_OFF_BUSDIV, 32'h9);
    gap(0, 1024);
    wr(SCRC_OFF_BUSDIV, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(SCRC_OFF_PDIV0, 32'(k) | (32'(k) << 28));
      wr(SCRC_OFF_PRST, 32'h0600_0040);
      gap(1, 2 << k);
      gap(6, 2 << k);
    end
    wr(SCRC_OFF_PDIV1, 32'h0050_0000);
    wr(SCRC_OFF_PRST, 32'h0100_0000);
    gap(2, 64);
    wr(SCRC_OFF_GATE, 32'h4000_0008);
    gap(4, 2);
    `CHK("pbus_gated", 32'h0, pbtick & 32'hFFFF_FFF7)
    for (int n = 0; n < 4; n++) begin
      wr(SCRC_OFF_PDIV1, 32'(n) << 28);
      gap(3, 2 << n);
    end
    // Bus clock as clock-out source, bus slowed so it differs from the oscillators
    wr(SCRC_OFF_PDIV1, 32'h0);
    wr(SCRC_OFF_BUSDIV, 32'h1);
    wr(SCRC_OFF_GATE, 32'h1000_0008);
    gap(3, 4);
    wr(SCRC_OFF_GATE, 32'h6000_0008);
    gap(3, 2);
    @(posedge clk_in);
    prd_r <= $random(seed);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("gated_on", prd_r, prdout)
    @(posedge clk_in);
    pidx_r <= 5'h18;
    @(posedge clk_in);
    pidx_r <= 5'h03;
    #1;
    `CHK("gated_idx", 32'h0, prdout)
    wr(SCRC_OFF_GATE, 32'h0);
    @(posedge clk_in);
    #1;
    `CHK("gated_off", 32'h0, prdout)
    end_sim();
  end
endmodule // tb_scrc_top
